// ---- hw/asram_host.sv ----
// Host controller that runs read and write cycles on an asynchronous 256K x 16 SRAM
`timescale 1ns/10ps
module asram_host #(
    parameter int POWER_UP_CYCLES = asram_pkg::POWER_UP_CYC,
    parameter bit WRITE_OE_LOW = 1'b0
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire asram_pkg::asram_req_s req_in,
    output logic req_ready_out,
    output logic rd_valid_out,
    output logic [asram_pkg::DATA_W-1:0] rd_data_out,
    output asram_pkg::asram_ctrl_s ctrl_out,
    output logic [asram_pkg::DATA_W-1:0] data_o_out,
    output logic [asram_pkg::DATA_W-1:0] data_oe_n_out,
    input wire logic [asram_pkg::DATA_W-1:0] data_i_in
);
    localparam int CW = asram_pkg::CNT_W;
    // With OE held low the pulse must cover turnoff plus setup as well
    localparam int PULSE_NEED = WRITE_OE_LOW ?
        ((asram_pkg::PULSE_ON_CYC > asram_pkg::TURNOFF_SETUP_CYC) ?
            asram_pkg::PULSE_ON_CYC : asram_pkg::TURNOFF_SETUP_CYC) : asram_pkg::PULSE_CYC;
    localparam int WCYC_NEED = (asram_pkg::WRITE_CYC > PULSE_NEED + 1) ? asram_pkg::WRITE_CYC : PULSE_NEED + 1;
    localparam logic [CW-1:0] LD_PULSE = CW'(PULSE_NEED - 1);
    localparam logic [CW-1:0] LD_WREC = CW'(WCYC_NEED - PULSE_NEED - 1);
    localparam logic [CW-1:0] LD_READ = CW'(asram_pkg::READ_CYC - 1);
    localparam logic [CW-1:0] LD_PWR = CW'(POWER_UP_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    asram_pkg::asram_state_e state_ff, nxt_state;
    asram_pkg::asram_ctrl_s ctrl_ff, nxt_ctrl;
    logic [asram_pkg::DATA_W-1:0] wdata_ff, nxt_wdata;
    logic drive_ff, nxt_drive;
    logic [1:0] lanes_ff, nxt_lanes;
    logic [asram_pkg::DATA_W-1:0] sync1_ff, sync2_ff;
    logic [asram_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic tmr_load;
    logic [CW-1:0] tmr_val;
    logic tmr_done;
    logic pwr_done_ff, nxt_pwr_done;

    asram_timer #(.CNT_W(CW)) u_timer (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .load_in(tmr_load),
        .load_val_in(tmr_val),
        .done_out(tmr_done)
    );

    // Lane mask from active-high lane enables, shared by read capture and drive
    function automatic logic [asram_pkg::DATA_W-1:0] lane_mask(input logic [1:0] en);
        lane_mask = {{asram_pkg::LANE_W{en[1]}}, {asram_pkg::LANE_W{en[0]}}};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: power-up wait, then one access at a time
    always_comb
    begin
        nxt_state = state_ff;
        nxt_ctrl = ctrl_ff;
        nxt_wdata = wdata_ff;
        nxt_drive = drive_ff;
        nxt_lanes = lanes_ff;
        nxt_rdata = rdata_ff;
        nxt_rvalid = 1'b0;
        nxt_pwr_done = pwr_done_ff;
        tmr_load = 1'b0;
        tmr_val = '0;
        unique case (state_ff)
            asram_pkg::ST_POWERUP:
            begin
                if (tmr_done && pwr_done_ff)
                begin
                    nxt_state = asram_pkg::ST_IDLE;
                end
                else if (!pwr_done_ff)
                begin
                    tmr_load = 1'b1;
                    tmr_val = LD_PWR;
                    nxt_pwr_done = 1'b1;
                end
            end
            asram_pkg::ST_IDLE:
            begin
                nxt_ctrl.chip_select_n = 1'b1;
                nxt_ctrl.write_strobe_n = 1'b1;
                nxt_ctrl.output_enable_n = 1'b1;
                nxt_drive = 1'b0;
                if (req_valid_in && req_in.lane_en != 2'b00)
                begin
                    nxt_ctrl.word_address = req_in.addr;
                    nxt_ctrl.chip_select_n = 1'b0;
                    nxt_ctrl.lower_lane_enable_n = !req_in.lane_en[0];
                    nxt_ctrl.upper_lane_enable_n = !req_in.lane_en[1];
                    nxt_lanes = req_in.lane_en;
                    tmr_load = 1'b1;
                    if (req_in.write)
                    begin
                        nxt_ctrl.write_strobe_n = 1'b0;
                        nxt_ctrl.output_enable_n = !WRITE_OE_LOW;
                        nxt_wdata = req_in.wdata;
                        nxt_drive = 1'b1;
                        tmr_val = LD_PULSE;
                        nxt_state = asram_pkg::ST_WPULSE;
                    end
                    else
                    begin
                        nxt_ctrl.output_enable_n = 1'b0;
                        tmr_val = LD_READ;
                        nxt_state = asram_pkg::ST_READ;
                    end
                end
            end
            asram_pkg::ST_WPULSE:
            begin
                if (tmr_done)
                begin
                    // Strobe rises first and ends the write; hold time is zero, so the
                    // drivers turn off at the same edge and never overlap read mode
                    nxt_ctrl.write_strobe_n = 1'b1;
                    nxt_drive = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = LD_WREC;
                    nxt_state = asram_pkg::ST_WREC;
                end
            end
            asram_pkg::ST_WREC:
            begin
                nxt_drive = 1'b0;
                if (tmr_done)
                begin
                    nxt_ctrl.chip_select_n = 1'b1;
                    nxt_ctrl.output_enable_n = 1'b1;
                    nxt_state = asram_pkg::ST_IDLE;
                end
            end
            asram_pkg::ST_READ:
            begin
                if (tmr_done)
                begin
                    // Sampled data is two flops late; capture at the end of a full cycle
                    nxt_rdata = sync2_ff & lane_mask(lanes_ff);
                    nxt_rvalid = 1'b1;
                    nxt_ctrl.chip_select_n = 1'b1;
                    nxt_ctrl.output_enable_n = 1'b1;
                    nxt_state = asram_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = asram_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state_ff <= asram_pkg::ST_POWERUP;
            ctrl_ff <= '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_enable_n: 1'b1,
                         lower_lane_enable_n: 1'b1, upper_lane_enable_n: 1'b1, word_address: '0};
            wdata_ff <= '0;
            drive_ff <= 1'b0;
            lanes_ff <= 2'b00;
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
            pwr_done_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            ctrl_ff <= nxt_ctrl;
            wdata_ff <= nxt_wdata;
            drive_ff <= nxt_drive;
            lanes_ff <= nxt_lanes;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            pwr_done_ff <= nxt_pwr_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser on the data pins; only the second stage is read
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= data_i_in;
            sync2_ff <= sync1_ff;
        end
    end

    // Drive only lanes in use, and never outside a write strobe phase
    assign data_oe_n_out = ~(lane_mask(lanes_ff) & {asram_pkg::DATA_W{drive_ff}});
    assign data_o_out = wdata_ff;
    assign ctrl_out = ctrl_ff;
    assign rd_data_out = rdata_ff;
    assign rd_valid_out = rvalid_ff;
    assign req_ready_out = (state_ff == asram_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    sequence s_wr_start;
        !ctrl_out.chip_select_n && !ctrl_out.write_strobe_n && $fell(ctrl_out.write_strobe_n);
    endsequence

    a_no_drive_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!ctrl_out.chip_select_n && ctrl_out.write_strobe_n)
        |-> (&data_oe_n_out))
        else $error("host drives bus in read mode");
    a_pulse_width: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_wr_start |-> (!ctrl_out.write_strobe_n)[*3])
        else $error("write strobe too short");
    a_write_cycle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        s_wr_start |-> (!ctrl_out.chip_select_n)[*5])
        else $error("write cycle too short");
    a_read_spacing: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == asram_pkg::ST_IDLE && nxt_state == asram_pkg::ST_READ)
        |=> (!ctrl_out.chip_select_n)[*5])
        else $error("read cycle too short");
    a_data_to_end: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $rose(ctrl_out.write_strobe_n) && !ctrl_out.chip_select_n |-> $past(!(&data_oe_n_out)))
        else $error("data released before write end");
    a_powerup_idle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state_ff == asram_pkg::ST_POWERUP) |-> ctrl_out.chip_select_n)
        else $error("access during power-up wait");
    a_lane_drive: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ctrl_out.lower_lane_enable_n && !ctrl_out.chip_select_n |-> (&data_oe_n_out[7:0]))
        else $error("disabled low lane driven");
    a_read_oe: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $rose(rd_valid_out) |-> $past(!ctrl_out.output_enable_n))
        else $error("read data taken without output enable");
endmodule // asram_host

// ---- hw/asram_pkg.sv ----
// Package: pin bundles, timing constants and states for the async SRAM host controller
// How it works
// - Host never drives bus during read mode
// - Write ends at first rising control edge
// - Read cycles spaced at least 20 ns
// - Write cycle lasts at least 20 ns
// - Strobe low 12 ns, 17 ns with outputs on
// - Outputs-on write covers turnoff plus setup
// - Wait 200 us after power before access
package asram_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int READ_CYCLE_MIN_PS = 20000;
    localparam int WRITE_CYCLE_MIN_PS = 20000;
    localparam int WRITE_PULSE_MIN_PS = 12000;
    localparam int WRITE_PULSE_MIN_OUTPUTS_ON_PS = 17000;
    localparam int WRITE_TURNOFF_DELAY_PS = 9000;
    localparam int WRITE_DATA_SETUP_PS = 9000;
    localparam int POWER_UP_WAIT_US = 200;
    // Least times round up to whole cycles
    localparam int READ_CYC = (READ_CYCLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_CYC = (WRITE_CYCLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_CYC = (WRITE_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_ON_CYC = (WRITE_PULSE_MIN_OUTPUTS_ON_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TURNOFF_SETUP_CYC =
        (WRITE_TURNOFF_DELAY_PS + WRITE_DATA_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POWER_UP_CYC = POWER_UP_WAIT_US * 1000000 / CLK_PERIOD_PS;
    localparam int CNT_W = 16;

    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic output_enable_n;
        logic lower_lane_enable_n;
        logic upper_lane_enable_n;
        logic [ADDR_W-1:0] word_address;
    } asram_ctrl_s;

    typedef struct packed {
        logic write;
        logic [1:0] lane_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asram_req_s;

    typedef enum logic [2:0] {
        ST_POWERUP = 3'b000,
        ST_IDLE = 3'b001,
        ST_WPULSE = 3'b011,
        ST_WREC = 3'b010,
        ST_READ = 3'b110
    } asram_state_e;
endpackage

// ---- hw/asram_timer.sv ----
// Down counter that times each controller phase
`timescale 1ns/10ps
module asram_timer #(
    parameter int CNT_W = 16
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [CNT_W-1:0] load_val_in,
    output logic done_out
);
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;

    // Load wins over the running count
    always_comb
    begin
        nxt_count = count_ff;
        if (load_in)
        begin
            nxt_count = load_val_in;
        end
        else if (count_ff != '0)
        begin
            nxt_count = count_ff - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            count_ff <= '0;
        end
        else
        begin
            count_ff <= nxt_count;
        end
    end

    // Done from the count alone: the sequencer loads on done, so gating it by load would loop
    assign done_out = (count_ff == '0);
endmodule // asram_timer

// ---- verification/asram_sram_model.sv ----
// Behavioural model of the 256K x 16 asynchronous memory with bus resolution
`timescale 1ns/10ps
module asram_sram_model (
    input wire asram_pkg::asram_ctrl_s ctrl_in,
    input wire logic [15:0] host_data_in,
    input wire logic [15:0] host_oe_n_in,
    output logic [15:0] bus_out,
    output logic clash_out
);
    logic [15:0] mem [0:262143];
    logic [15:0] junk = 16'h5A3C;
    logic [15:0] dev_drv;
    logic [15:0] host_on;
    logic sel;
    logic wr;
    logic rd;
    ////////////////////////////////////////////////////////////////////////////
    // Floating pins keep changing, so a stale value never reads as valid
    always #3 junk = ~junk;
    // Mode decode from the control pins
    assign sel = !ctrl_in.chip_select_n;
    assign wr = sel && !ctrl_in.write_strobe_n;
    assign rd = sel && ctrl_in.write_strobe_n && !ctrl_in.output_enable_n;
    // Only enabled lanes drive; both lanes off leaves the bus floating
    assign dev_drv = {{8{rd && !ctrl_in.upper_lane_enable_n}}, {8{rd && !ctrl_in.lower_lane_enable_n}}};
    // Host data lingers 1 ns on the trace, which gives the store its hold past the write end
    assign #1 host_on = ~host_oe_n_in;
    // Pin level from every party's enable
    assign bus_out = (host_on & host_data_in) | (~host_on & dev_drv & mem[ctrl_in.word_address])
        | (~host_on & ~dev_drv & junk);
    // Host drive in read mode is forbidden, whether the outputs are on or not
    assign clash_out = sel && ctrl_in.write_strobe_n && (|(~host_oe_n_in));
    ////////////////////////////////////////////////////////////////////////////
    // Store follows the pins for as long as the write overlap lasts
    always @(wr, ctrl_in, bus_out)
    begin
        if (wr && !ctrl_in.lower_lane_enable_n)
            mem[ctrl_in.word_address][7:0] = bus_out[7:0];
        if (wr && !ctrl_in.upper_lane_enable_n)
            mem[ctrl_in.word_address][15:8] = bus_out[15:8];
    end
endmodule // asram_sram_model

// ---- verification/test_asram_host.sv ----
// Self-checking bench for the async SRAM host controller
`timescale 1ns/10ps
module test_asram_host;
    localparam int PU = 4;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    asram_pkg::asram_req_s req_in = '0;
    logic req_ready_out, rd_valid_out, clash;
    logic [15:0] rd_data_out, data_o_out, data_oe_n_out, bus;
    asram_pkg::asram_ctrl_s ctrl_out, ctrl_oe;
    logic [15:0] do_oe, oen_oe, bus_oe;
    logic clash_oe;
    int we_oe_low = 0;
    logic [15:0] shadow [0:262143];
    logic [17:0] addrs [0:7];
    logic [15:0] exp_q [$];
    int bad_count = 0, checks_done = 0, seed = 30197, cycles = 0, we_low = 0, cs_low = 0, pu_wait = 0;
    bit seen_cs = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    asram_host #(.POWER_UP_CYCLES(PU), .WRITE_OE_LOW(1'b0)) i_dut (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .ctrl_out(ctrl_out),
        .data_o_out(data_o_out), .data_oe_n_out(data_oe_n_out), .data_i_in(bus));
    asram_sram_model i_mem (.ctrl_in(ctrl_out), .host_data_in(data_o_out), .host_oe_n_in(data_oe_n_out),
        .bus_out(bus), .clash_out(clash));
    // Second pair keeps OE low in writes; only its strobe length, OE level during the strobe and bus fights are checked
    asram_host #(.POWER_UP_CYCLES(PU), .WRITE_OE_LOW(1'b1)) i_dut_oe (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(),
        .rd_valid_out(), .rd_data_out(), .ctrl_out(ctrl_oe),
        .data_o_out(do_oe), .data_oe_n_out(oen_oe), .data_i_in(bus_oe));
    asram_sram_model i_mem_oe (.ctrl_in(ctrl_oe), .host_data_in(do_oe), .host_oe_n_in(oen_oe),
        .bus_out(bus_oe), .clash_out(clash_oe));
    // Free-running 250 MHz clock
    initial
    begin
        forever #2 core_clk_in = ~core_clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Present one request; the posedge after a ready negedge takes it
    task automatic send(input logic wr, input logic [1:0] ln, input logic [17:0] a, input logic [15:0] d);
        int n;
        @(negedge core_clk_in);
        req_valid_in = 1'b1;
        req_in = '{write: wr, lane_en: ln, addr: a, wdata: d};
        n = 0;
        while (req_ready_out !== 1'b1 && n < 100)
        begin
            @(negedge core_clk_in);
            n++;
        end
        if (wr && ln[0])
            shadow[a][7:0] = d[7:0];
        if (wr && ln[1])
            shadow[a][15:8] = d[15:8];
        if (!wr)
            exp_q.push_back({ln[1] ? shadow[a][15:8] : 8'h00, ln[0] ? shadow[a][7:0] : 8'h00});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Output watcher: read results, pin timing and bus fights
    always @(negedge core_clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            end_of_test();
        end
        if (rd_valid_out === 1'b1 && exp_q.size() > 0)
            check(rd_data_out, exp_q.pop_front());
        else if (rd_valid_out === 1'b1)
            check(16'h0001, 16'h0000);
        check({15'h0, clash}, 16'h0000);
        check({15'h0, clash_oe}, 16'h0000);
        if (ctrl_oe.write_strobe_n === 1'b0)
        begin
            we_oe_low++;
            check({15'h0, ctrl_oe.output_enable_n}, 16'h0000);
        end
        else if (we_oe_low != 0)
        begin
            check({15'h0, we_oe_low >= asram_pkg::PULSE_ON_CYC}, 16'h0001);
            check({15'h0, we_oe_low >= asram_pkg::TURNOFF_SETUP_CYC}, 16'h0001);
            we_oe_low = 0;
        end
        if (ctrl_out.write_strobe_n === 1'b0)
        begin
            we_low++;
            check({15'h0, !ctrl_out.chip_select_n && !(ctrl_out.lower_lane_enable_n && ctrl_out.upper_lane_enable_n)}, 16'h0001);
        end
        else if (we_low != 0)
        begin
            check({15'h0, we_low >= asram_pkg::PULSE_CYC}, 16'h0001);
            we_low = 0;
        end
        if (ctrl_out.chip_select_n === 1'b0)
            cs_low++;
        else if (cs_low != 0)
        begin
            check({15'h0, cs_low >= asram_pkg::READ_CYC && cs_low >= asram_pkg::WRITE_CYC}, 16'h0001);
            cs_low = 0;
        end
        // Power-up wait counts from reset release to the first select
        if (!rst_in && !seen_cs)
        begin
            pu_wait++;
            if (ctrl_out.chip_select_n === 1'b0)
            begin
                seen_cs = 1'b1;
                check({15'h0, pu_wait > PU}, 16'h0001);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        int i;
        logic [31:0] r;
        repeat (2) @(negedge core_clk_in);
        check({11'h0, ctrl_out.chip_select_n, ctrl_out.write_strobe_n, ctrl_out.output_enable_n,
            &data_oe_n_out, req_ready_out}, 16'h001E);
        rst_in = 1'b0;
        addrs[0] = 18'h0_0000;
        addrs[1] = 18'h3_FFFF;
        for (i = 2; i < 8; i++)
        begin
            r = $random(seed);
            addrs[i] = r[17:0];
        end
        for (i = 0; i < 8; i++)
        begin
            r = $random(seed);
            send(1'b1, 2'h3, addrs[i], r[15:0]);
        end
        // Empty lane mask before ready returns: never started, never consumed
        @(negedge core_clk_in);
        req_in.lane_en = 2'h0;
        repeat (8) @(negedge core_clk_in);
        repeat (4)
        begin
            @(negedge core_clk_in);
            check({14'h0, ctrl_out.chip_select_n, req_ready_out}, 16'h0003);
        end
        // Every non-empty lane mask on reads, then single-lane writes checked by full reads
        for (i = 0; i < 24; i++)
            send(1'b0, 2'(i % 3) + 2'h1, addrs[i % 8], 16'h0000);
        for (i = 0; i < 8; i++)
        begin
            r = $random(seed);
            send(1'b1, (i % 2) ? 2'h2 : 2'h1, addrs[i], r[15:0]);
            send(1'b0, 2'h3, addrs[i], 16'h0000);
        end
        // Random back-to-back traffic
        for (i = 0; i < 60; i++)
        begin
            r = $random(seed);
            send(r[31], 2'(r[23:16] % 8'h03) + 2'h1, addrs[r[26:24]], r[15:0]);
        end
        @(negedge core_clk_in);
        req_valid_in = 1'b0;
        repeat (20) @(negedge core_clk_in);
        check(16'(exp_q.size()), 16'h0000);
        end_of_test();
    end
endmodule // test_asram_host
